// ===== rtl/spr_pkg.sv
// Constants, register map and types for the production signature row loader
//
// Overview of operation
// - At every reset release, the byte at offset 0x00 loads the 8MHz oscillator trim.
// - At every reset release, the byte at offset 0x02 loads the 32.768kHz oscillator trim.
// - At every reset release, the byte at offset 0x03 loads loop calibration register B.
// - At every reset release, the byte at offset 0x04 loads loop calibration register A.
// - Six lot number bytes sit at offsets 0x08 to 0x0D, byte n at 0x08 plus n.
// - Wafer number is one byte at offset 0x10; its top three bits read zero.
// - Die X sits at 0x12/0x13 and die Y at 0x14/0x15, low byte first.
// - Lot, wafer and both coordinates together form the unique serial identity.
// - Values come from the factory-programmed row and are specific to each device.
package spr_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] OSC8_TRIM_VALUE_IDX     = 6'h00;
    localparam logic [5:0] OSC_SLOW_TRIM_VALUE_IDX = 6'h02;
    localparam logic [5:0] LOOP_TRIM_B_VALUE_IDX   = 6'h03;
    localparam logic [5:0] LOOP_TRIM_A_VALUE_IDX   = 6'h04;
    localparam logic [5:0] LOT_ID_BYTE0_IDX        = 6'h08;
    localparam logic [5:0] LOT_ID_BYTE1_IDX        = 6'h09;
    localparam logic [5:0] LOT_ID_BYTE2_IDX        = 6'h0a;
    localparam logic [5:0] LOT_ID_BYTE3_IDX        = 6'h0b;
    localparam logic [5:0] LOT_ID_BYTE4_IDX        = 6'h0c;
    localparam logic [5:0] LOT_ID_BYTE5_IDX        = 6'h0d;
    localparam logic [5:0] WAFER_INDEX_IDX         = 6'h10;
    localparam logic [5:0] DIE_X_LOW_IDX           = 6'h12;
    localparam logic [5:0] DIE_X_HIGH_IDX          = 6'h13;
    localparam logic [5:0] DIE_Y_LOW_IDX           = 6'h14;
    localparam logic [5:0] DIE_Y_HIGH_IDX          = 6'h15;

    // ------------------------------------------------------------------
    // Widths, entries and field values
    // ------------------------------------------------------------------
    localparam int         SPR_ADDR_W      = 8;
    localparam int         SPR_ROW_ADDR_W  = 6;
    localparam int         SPR_NUM_ENTRIES = 15;
    localparam int         SPR_SERIAL_W    = 88;
    localparam logic [3:0] SPR_LAST_ENTRY  = 4'he;
    localparam logic [7:0] SPR_BYTE_RESET  = 8'h00;
    localparam logic [7:0] SPR_ALL_BITS    = 8'hff;
    localparam logic [7:0] SPR_WAFER_MASK  = 8'h1f;

    // Load order: the four trims first so the clock system settles soonest
    localparam logic [3:0] SPR_ENT_OSC8    = 4'h0;
    localparam logic [3:0] SPR_ENT_SLOW    = 4'h1;
    localparam logic [3:0] SPR_ENT_LOOP_B  = 4'h2;
    localparam logic [3:0] SPR_ENT_LOOP_A  = 4'h3;

    localparam logic [5:0] SPR_ENTRY_IDX [SPR_NUM_ENTRIES] = '{
        OSC8_TRIM_VALUE_IDX, OSC_SLOW_TRIM_VALUE_IDX, LOOP_TRIM_B_VALUE_IDX, LOOP_TRIM_A_VALUE_IDX,
        LOT_ID_BYTE0_IDX, LOT_ID_BYTE1_IDX, LOT_ID_BYTE2_IDX, LOT_ID_BYTE3_IDX,
        LOT_ID_BYTE4_IDX, LOT_ID_BYTE5_IDX, WAFER_INDEX_IDX,
        DIE_X_LOW_IDX, DIE_X_HIGH_IDX, DIE_Y_LOW_IDX, DIE_Y_HIGH_IDX
    };

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SPR_ST_FETCH   = 2'b00,
        SPR_ST_CAPTURE = 2'b01,
        SPR_ST_DONE    = 2'b10
    } spr_load_st_t;

endpackage

// ===== rtl/spr_byte_reg.sv
// One signature byte holder with a fixed mask of implemented bits
`timescale 1ns/1ps
module spr_byte_reg
    import spr_pkg::*;
#(
    parameter logic [7:0] KEEP_MASK = 8'hff
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       load,
    input  wire logic [7:0] d,
    output logic      [7:0] q
);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= SPR_BYTE_RESET;
        end else if (load) begin
            q <= d & KEEP_MASK;
        end
    end

endmodule

// ===== rtl/spr_signature_row.sv
// Production signature row: reset-time trim loader and read-only APB register file
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module spr_signature_row
    import spr_pkg::*;
(
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [SPR_ADDR_W-1:0]     paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Factory-programmed row, read combinationally from the registered address
    output logic                           row_rd_en,
    output logic      [SPR_ROW_ADDR_W-1:0] row_rd_addr,
    input  wire logic [7:0]                row_rdata,
    // Clock system calibration targets
    output logic      [7:0]                fast_osc_calibration_target,
    output logic      [7:0]                slow_osc_calibration_target,
    output logic      [7:0]                loop_calibration_target_a,
    output logic      [7:0]                loop_calibration_target_b,
    output logic                           cal_loaded,
    // Per-die identity
    output logic      [SPR_SERIAL_W-1:0]   die_serial
);

    // ------------------------------------------------------------------
    // Loader state
    // ------------------------------------------------------------------
    spr_load_st_t state;
    logic [3:0]   entry;
    logic [7:0]   sig_byte [SPR_NUM_ENTRIES];
    logic         capture;

    assign capture = (state == SPR_ST_CAPTURE);

    // The sequence reruns after every reset, so trims never depend on software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= SPR_ST_FETCH;
            entry       <= 4'h0;
            row_rd_en   <= 1'b0;
            row_rd_addr <= '0;
        end else begin
            unique case (state)
                SPR_ST_FETCH: begin
                    row_rd_en   <= 1'b1;
                    row_rd_addr <= SPR_ENTRY_IDX[entry];
                    state       <= SPR_ST_CAPTURE;
                end
                SPR_ST_CAPTURE: begin
                    row_rd_en <= 1'b0;
                    if (entry == SPR_LAST_ENTRY) begin
                        state <= SPR_ST_DONE;
                    end else begin
                        entry <= entry + 4'h1;
                        state <= SPR_ST_FETCH;
                    end
                end
                SPR_ST_DONE: begin
                    row_rd_en <= 1'b0;
                end
                default: begin
                    state <= SPR_ST_FETCH;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_loaded <= 1'b0;
        end else if (capture && entry == SPR_LAST_ENTRY) begin
            cal_loaded <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Trim copies into the clock system
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_osc_calibration_target <= SPR_BYTE_RESET;
            slow_osc_calibration_target <= SPR_BYTE_RESET;
            loop_calibration_target_a   <= SPR_BYTE_RESET;
            loop_calibration_target_b   <= SPR_BYTE_RESET;
        end else if (capture) begin
            if (entry == SPR_ENT_OSC8) begin
                fast_osc_calibration_target <= row_rdata;
            end
            if (entry == SPR_ENT_SLOW) begin
                slow_osc_calibration_target <= row_rdata;
            end
            if (entry == SPR_ENT_LOOP_B) begin
                loop_calibration_target_b <= row_rdata;
            end
            if (entry == SPR_ENT_LOOP_A) begin
                loop_calibration_target_a <= row_rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Signature byte holders
    // ------------------------------------------------------------------
    // Values come only from the factory row, never from the bus
    genvar k;
    generate
        for (k = 0; k < SPR_NUM_ENTRIES; k++) begin : g_byte
            spr_byte_reg #(
                .KEEP_MASK ((SPR_ENTRY_IDX[k] == WAFER_INDEX_IDX) ? SPR_WAFER_MASK : SPR_ALL_BITS)
            ) u_byte (
                .pclk    (pclk),
                .presetn (presetn),
                .load    (capture && entry == 4'(k)),
                .d       (row_rdata),
                .q       (sig_byte[k])
            );
        end
    endgenerate

    // Serial identity: lot (byte 0 lowest), wafer, X, Y
    assign die_serial = {sig_byte[14], sig_byte[13], sig_byte[12], sig_byte[11], sig_byte[10],
                         sig_byte[9], sig_byte[8], sig_byte[7], sig_byte[6], sig_byte[5],
                         sig_byte[4]};

    // ------------------------------------------------------------------
    // APB read decode
    // ------------------------------------------------------------------
    logic       hit;
    logic [7:0] rd_byte;

    always_comb begin
        hit     = 1'b0;
        rd_byte = SPR_BYTE_RESET;
        if (paddr[1:0] == 2'b00) begin
            for (int i = 0; i < SPR_NUM_ENTRIES; i++) begin
                if (paddr[SPR_ADDR_W-1:2] == SPR_ENTRY_IDX[i]) begin
                    hit     = 1'b1;
                    rd_byte = sig_byte[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    // Answers wait for the loader so software never sees a half-filled row
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready && cal_loaded) begin
            pready  <= 1'b1;
            prdata  <= (hit && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= !hit;
        end else begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Write data is deliberately dropped: the row is read-only
    logic unused_wdata;
    assign unused_wdata = ^pwdata;

endmodule

// ===== tb/spr_row_model.sv
// Factory-programmed row model feeding the loader
`timescale 1ns/1ps
module spr_row_model (
    input  wire logic [5:0] row_rd_addr,
    input  wire logic       row_rd_en,
    input  wire logic [7:0] die_pick,
    output logic      [7:0] row_rdata
);
    // Content differs per die_pick so each die looks distinct; inverted outside fetches
    function automatic logic [7:0] val(input logic [5:0] i, input logic [7:0] s);
        return (8'(i) * 8'h1d + 8'hc3) ^ s;
    endfunction
    assign row_rdata = row_rd_en ? val(row_rd_addr, die_pick) : ~val(row_rd_addr, die_pick);
endmodule

// ===== tb/spr_signature_row_monitor.sv
// Port-level assertions for the signature row loader
`timescale 1ns/1ps
module spr_signature_row_monitor
    import spr_pkg::*;
(
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      pready,
    input wire logic                      pslverr,
    input wire logic [31:0]               prdata,
    input wire logic                      row_rd_en,
    input wire logic [SPR_ROW_ADDR_W-1:0] row_rd_addr,
    input wire logic [7:0]                row_rdata,
    input wire logic [7:0]                fast_osc_calibration_target,
    input wire logic [7:0]                slow_osc_calibration_target,
    input wire logic [7:0]                loop_calibration_target_a,
    input wire logic [7:0]                loop_calibration_target_b,
    input wire logic                      cal_loaded,
    input wire logic [SPR_SERIAL_W-1:0]   die_serial
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_fast; row_rd_en && row_rd_addr == 6'h00 |=> fast_osc_calibration_target == $past(row_rdata); endproperty
    a_fast: assert property (p_fast) else $error("fast trim not loaded");
    property p_slow; row_rd_en && row_rd_addr == 6'h02 |=> slow_osc_calibration_target == $past(row_rdata); endproperty
    a_slow: assert property (p_slow) else $error("slow trim not loaded");
    property p_b; row_rd_en && row_rd_addr == 6'h03 |=> loop_calibration_target_b == $past(row_rdata); endproperty
    a_b: assert property (p_b) else $error("loop trim b not loaded");
    property p_a; row_rd_en && row_rd_addr == 6'h04 |=> loop_calibration_target_a == $past(row_rdata); endproperty
    a_a: assert property (p_a) else $error("loop trim a not loaded");
    property p_lot; row_rd_en && row_rd_addr == 6'h0d |=> die_serial[47:40] == $past(row_rdata); endproperty
    a_lot: assert property (p_lot) else $error("lot byte 5 wrong");
    property p_waf; row_rd_en && row_rd_addr == 6'h10 |=> die_serial[55:48] == ($past(row_rdata) & 8'h1f); endproperty
    a_waf: assert property (p_waf) else $error("wafer byte wrong");
    property p_hold;
        cal_loaded |=> cal_loaded && $stable(die_serial) && $stable(fast_osc_calibration_target)
            && $stable(slow_osc_calibration_target) && $stable(loop_calibration_target_a)
            && $stable(loop_calibration_target_b);
    endproperty
    a_hold: assert property (p_hold) else $error("loaded values moved");
    property p_rd; pready |-> cal_loaded && prdata[31:8] == 24'h0 ##1 !pready; endproperty
    a_rd: assert property (p_rd) else $error("bad read answer");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("error without clean answer");
endmodule

bind spr_signature_row spr_signature_row_monitor u_mon (.pclk(pclk), .presetn(presetn), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .row_rd_en(row_rd_en), .row_rd_addr(row_rd_addr), .row_rdata(row_rdata),
    .fast_osc_calibration_target(fast_osc_calibration_target), .slow_osc_calibration_target(slow_osc_calibration_target),
    .loop_calibration_target_a(loop_calibration_target_a), .loop_calibration_target_b(loop_calibration_target_b),
    .cal_loaded(cal_loaded), .die_serial(die_serial));

// ===== tb/production_signature_row_tb_top.sv
// Testbench for the signature row loader and its APB view
`timescale 1ns/1ps
module production_signature_row_tb_top
    import spr_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0, die_pick = 0, rdat, fo, so, la, lb;
    logic [7:0]  bad_addr [4] = '{8'h04, 8'h14, 8'h01, 8'hfc};
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, row_rd_en, cal_loaded, er;
    logic [5:0]  row_rd_addr;
    logic [87:0] die_serial, ex;
    int          n_fail = 0, n_compared = 0, cyc = 0;
    always #5 pclk = ~pclk;
    spr_row_model row (.row_rd_addr(row_rd_addr), .row_rd_en(row_rd_en), .die_pick(die_pick), .row_rdata(rdat));
    spr_signature_row dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .row_rd_en(row_rd_en),
        .row_rd_addr(row_rd_addr), .row_rdata(rdat), .fast_osc_calibration_target(fo),
        .slow_osc_calibration_target(so), .loop_calibration_target_a(la), .loop_calibration_target_b(lb),
        .cal_loaded(cal_loaded), .die_serial(die_serial));
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [87:0] got, input logic [87:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Setup then access phase held until pready; one idle cycle between transfers
    task automatic apb(input logic w, input logic [7:0] a);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= 32'hffffffff;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    function automatic logic [7:0] expv(input logic [5:0] i);
        return row.val(i, die_pick) & (i == WAFER_INDEX_IDX ? SPR_WAFER_MASK : SPR_ALL_BITS);
    endfunction
    task automatic chk_ports();
        chk(fo, expv(6'h00));
        chk(so, expv(6'h02));
        chk(lb, expv(6'h03));
        chk(la, expv(6'h04));
        for (int j = 0; j < 11; j++) ex[j*8+:8] = expv(SPR_ENTRY_IDX[j+4]);
        chk(die_serial, ex);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        // Read issued while the loader is still running must stall, then answer
        apb(0, 8'h00);
        chk(rd, {24'h0, expv(6'h00)});
        chk_ports();
        for (int i = 0; i < SPR_NUM_ENTRIES; i++) begin
            apb(1, {SPR_ENTRY_IDX[i], 2'b00});
            chk(er, 1'b0);
            apb(0, {SPR_ENTRY_IDX[i], 2'b00});
            chk(rd, {24'h0, expv(SPR_ENTRY_IDX[i])});
        end
        foreach (bad_addr[k]) begin
            apb(1'(k % 2), bad_addr[k]);
            chk({rd, er}, 33'h1);
        end
        // Reset in mid-run with a new die: every trim must reload
        @(posedge pclk);
        presetn <= 0;
        die_pick <= 8'h5a;
        repeat (3) @(posedge pclk);
        presetn <= 1;
        repeat (32) @(posedge pclk);
        chk(cal_loaded, 1'b1);
        chk_ports();
        tally_and_finish();
    end
endmodule
